// [hdl/uart_with_baud_generator.sv]
// Serial port with baud generator, receive queue and register port.
//
// Behaviour
// R1 - Three byte receive queue; extra byte is overrun.
// R2 - Data port writes go to transmit holding.
// R3 - Data port reads return oldest received byte.
// R4 - Done and ready flags raise interrupt request.
// R5 - Flags stay set until software clears them.
// R6 - Ready clear ignored while queue holds bytes.
// R7 - Baud timer clocked through 1/4/12/48 prescaler.
// R8 - No transfer unless baud generator enabled.
// R9 - Timer counts up, reloads on overflow.
// R10 - Two overflows per bit time.
// R11 - Software keeps rate below core clock/16.
// R12 - Multiprocessor check gates ready on extra bit.
// R13 - Multiprocessor check off while parity enabled.
// R14 - Frame format register layout and reset value.
// R15 - Parity generated and checked when enabled.
// R16 - Parity kind odd, even, mark, space.
// R17 - Start low, data LSB first, extra, stops.
`timescale 1ns/1ps

module uart_with_baud_generator (
  // Clock, reset and enable
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  // Register port
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  output logic [7:0] o_sfr_rdata,
  // Serial lines
  input wire logic i_rxd,
  output logic o_txd,
  // Interrupt request
  output logic o_irq_req
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] frame_reg;
    logic [7:0] reload_lo_reg;
    logic [7:0] reload_hi_reg;
    logic baud_en;
    logic [1:0] presc_sel;
    logic [5:0] presc_cnt;
    logic [15:0] baud_timer;
    logic rx_en;
    logic tx_extra;
    logic rx_extra;
    logic rx_ready;
    logic tx_done;
    logic overrun;
    logic par_err;
    logic [7:0] thr;
    logic thr_full;
    uart_pkg::line_state_t tx_state;
    logic [4:0] tx_hcnt;
    logic [4:0] tx_last;
    logic [11:0] tx_frame;
    uart_pkg::line_state_t rx_state;
    logic rx_prev;
    logic [15:0] rx_timer;
    logic [4:0] rx_hcnt;
    logic [11:0] rx_bits;
    logic [2:0][7:0] fifo;
    logic [1:0] fifo_cnt;
    logic txd;
    logic [7:0] rdata;
    logic irq;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic [1:0] rst_sync_reg;
  logic rst_n;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic parity_of(input logic [7:0] d,
                                     input logic [3:0] n,
                                     input logic [1:0] kind);
    logic x;
    logic r;
    x = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      if (4'(i) < n)
      begin
        x = x ^ d[i];
      end
    end
    unique case (uart_pkg::parity_kind_t'(kind))
      uart_pkg::PAR_ODD: r = ~x;
      uart_pkg::PAR_EVEN: r = x;
      uart_pkg::PAR_MARK: r = 1'b1;
      uart_pkg::PAR_SPACE: r = 1'b0;
    endcase
    return r;
  endfunction : parity_of

  function automatic logic [7:0] mask_data(input logic [7:0] d,
                                           input logic [3:0] n);
    logic [7:0] r;
    for (int i = 0; i < 8; i++)
    begin
      r[i] = (4'(i) < n) ? d[i] : 1'b0;
    end
    return r;
  endfunction : mask_data

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rst_sync_reg <= 2'h0;
    end
    else
    begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic [5:0] presc_end;
    logic tick;
    logic tx_ovf;
    logic rx_ovf;
    logic [15:0] reload;
    logic [3:0] nbits;
    logic has_x;
    logic [4:0] stop_half;
    logic [3:0] stop_idx;
    logic [3:0] idx;
    logic [7:0] rx_data;
    logic xbit;
    logic accept;
    logic [1:0] cnt;
    state_next = state_reg;
    reload = {state_reg.reload_hi_reg, state_reg.reload_lo_reg};
    nbits = uart_pkg::DATA_BITS_MIN
            + {2'h0, state_reg.frame_reg[uart_pkg::FF_DL_HI:uart_pkg::FF_DL_LO]};
    has_x = state_reg.frame_reg[uart_pkg::FF_PE]
            | state_reg.frame_reg[uart_pkg::FF_XBE];
    if (!state_reg.frame_reg[uart_pkg::FF_SBL])
    begin
      stop_half = uart_pkg::STOP_HALF_SHORT;
    end
    else if (nbits == uart_pkg::DATA_BITS_MIN)
    begin
      stop_half = uart_pkg::STOP_HALF_MID;
    end
    else
    begin
      stop_half = uart_pkg::STOP_HALF_LONG;
    end
    stop_idx = nbits + {3'h0, has_x} + 4'h1;
    idx = state_reg.rx_hcnt[4:1];
    rx_data = mask_data(state_reg.rx_bits[8:1], nbits);
    xbit = state_reg.rx_bits[nbits + 4'h1];
    accept = 1'b0;
    cnt = 2'h0;
    presc_end = uart_pkg::PRESC_END_1;

    // Prescaler shared by both directions; transmit baud timer.
    unique case (state_reg.presc_sel)
      2'h0: presc_end = uart_pkg::PRESC_END_1;
      2'h1: presc_end = uart_pkg::PRESC_END_4;
      2'h2: presc_end = uart_pkg::PRESC_END_12;
      2'h3: presc_end = uart_pkg::PRESC_END_48;
    endcase
    tick = state_reg.baud_en && (state_reg.presc_cnt >= presc_end); // see R7
    tx_ovf = tick && (state_reg.baud_timer == uart_pkg::TIMER_TOP);
    rx_ovf = tick && (state_reg.rx_timer == uart_pkg::TIMER_TOP);
    if (!state_reg.baud_en || tick)
    begin
      state_next.presc_cnt = 6'h00;
    end
    else
    begin
      state_next.presc_cnt = state_reg.presc_cnt + 6'h01;
    end
    if (!state_reg.baud_en || tx_ovf)
    begin
      state_next.baud_timer = reload; // see R9
    end
    else if (tick)
    begin
      state_next.baud_timer = state_reg.baud_timer + 16'h0001; // see R9
    end

    // Register writes.
    if (i_sfr_wr)
    begin
      unique case (i_sfr_addr)
        uart_pkg::ADDR_FRAME_FORMAT: state_next.frame_reg = i_sfr_wdata; // see R14
        uart_pkg::ADDR_RELOAD_LO: state_next.reload_lo_reg = i_sfr_wdata;
        uart_pkg::ADDR_RELOAD_HI: state_next.reload_hi_reg = i_sfr_wdata;
        uart_pkg::ADDR_BAUD_CTL:
        begin
          state_next.baud_en = i_sfr_wdata[uart_pkg::BC_ENABLE];
          state_next.presc_sel =
            i_sfr_wdata[uart_pkg::BC_PRESC_HI:uart_pkg::BC_PRESC_LO];
        end
        uart_pkg::ADDR_DATA:
        begin
          state_next.thr = i_sfr_wdata; // see R2
          state_next.thr_full = 1'b1;
        end
        uart_pkg::ADDR_CONTROL:
        begin
          state_next.tx_extra = i_sfr_wdata[uart_pkg::CS_TX_EXTRA];
          state_next.rx_en = i_sfr_wdata[uart_pkg::CS_RX_EN];
          state_next.tx_done = state_reg.tx_done
                               & i_sfr_wdata[uart_pkg::CS_TX_DONE]; // see R5
          state_next.overrun = state_reg.overrun
                               & i_sfr_wdata[uart_pkg::CS_OVERRUN];
          state_next.par_err = state_reg.par_err
                               & i_sfr_wdata[uart_pkg::CS_PAR_ERR];
        end
        default: ;
      endcase
    end

    // Register reads; a data read pops the oldest byte.
    if (i_sfr_rd)
    begin
      unique case (i_sfr_addr)
        uart_pkg::ADDR_FRAME_FORMAT: state_next.rdata = state_reg.frame_reg;
        uart_pkg::ADDR_RELOAD_LO: state_next.rdata = state_reg.reload_lo_reg;
        uart_pkg::ADDR_RELOAD_HI: state_next.rdata = state_reg.reload_hi_reg;
        uart_pkg::ADDR_BAUD_CTL:
          state_next.rdata = {1'b0, state_reg.baud_en, 4'h0,
                              state_reg.presc_sel};
        uart_pkg::ADDR_CONTROL:
          state_next.rdata = {state_reg.tx_state == uart_pkg::LINE_BUSY
                              || state_reg.thr_full,
                              state_reg.overrun, state_reg.par_err,
                              state_reg.rx_en, state_reg.tx_extra,
                              state_reg.rx_extra, state_reg.tx_done,
                              state_reg.rx_ready};
        uart_pkg::ADDR_DATA:
        begin
          state_next.rdata = state_reg.fifo[0]; // see R3
          if (state_reg.fifo_cnt != 2'h0)
          begin
            state_next.fifo[0] = state_reg.fifo[1];
            state_next.fifo[1] = state_reg.fifo[2];
            state_next.fifo_cnt = state_reg.fifo_cnt - 2'h1;
          end
        end
        default: state_next.rdata = 8'h00;
      endcase
    end

    // Clearing ready only succeeds once the queue is empty.
    if (i_sfr_wr && (i_sfr_addr == uart_pkg::ADDR_CONTROL)
        && !i_sfr_wdata[uart_pkg::CS_RX_READY])
    begin
      state_next.rx_ready = (state_next.fifo_cnt != 2'h0); // see R6
    end

    // Transmitter.
    if (!state_reg.baud_en)
    begin
      state_next.tx_state = uart_pkg::LINE_IDLE; // see R8
    end
    else if (state_reg.tx_state == uart_pkg::LINE_IDLE)
    begin
      if (state_reg.thr_full)
      begin
        state_next.tx_state = uart_pkg::LINE_BUSY;
        state_next.thr_full = i_sfr_wr
                              && (i_sfr_addr == uart_pkg::ADDR_DATA); // see R2
        state_next.tx_hcnt = 5'h00;
        state_next.tx_last = 5'({stop_idx, 1'b0}) + stop_half - 5'h01; // see R10
        state_next.tx_frame = 12'hFFF;
        state_next.tx_frame[0] = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
          if (4'(i) < nbits)
          begin
            state_next.tx_frame[i + 1] = state_reg.thr[i]; // see R17
          end
        end
        if (state_reg.frame_reg[uart_pkg::FF_PE])
        begin
          state_next.tx_frame[nbits + 4'h1] =
            parity_of(state_reg.thr, nbits,
                      state_reg.frame_reg[uart_pkg::FF_PKIND_HI:
                                          uart_pkg::FF_PKIND_LO]); // see R15, R16
        end
        else if (state_reg.frame_reg[uart_pkg::FF_XBE])
        begin
          state_next.tx_frame[nbits + 4'h1] = state_reg.tx_extra;
        end
      end
    end
    else if (tx_ovf)
    begin
      if (state_reg.tx_hcnt == state_reg.tx_last)
      begin
        state_next.tx_state = uart_pkg::LINE_IDLE;
        state_next.tx_done = 1'b1; // see R4
      end
      else
      begin
        state_next.tx_hcnt = state_reg.tx_hcnt + 5'h01;
      end
    end

    // Receiver.
    state_next.rx_prev = i_rxd;
    if (!state_reg.baud_en)
    begin
      state_next.rx_state = uart_pkg::LINE_IDLE; // see R8
    end
    else if (state_reg.rx_state == uart_pkg::LINE_IDLE)
    begin
      if (state_reg.rx_en && state_reg.rx_prev && !i_rxd)
      begin
        state_next.rx_state = uart_pkg::LINE_BUSY;
        state_next.rx_timer = reload;
        state_next.rx_hcnt = 5'h00;
      end
    end
    else
    begin
      if (rx_ovf)
      begin
        state_next.rx_timer = reload;
        state_next.rx_hcnt = state_reg.rx_hcnt + 5'h01;
      end
      else if (tick)
      begin
        state_next.rx_timer = state_reg.rx_timer + 16'h0001;
      end
      if (rx_ovf && !state_reg.rx_hcnt[0])
      begin
        state_next.rx_bits[idx] = i_rxd;
        if ((idx == 4'h0) && i_rxd)
        begin
          state_next.rx_state = uart_pkg::LINE_IDLE;
        end
        else if (idx == stop_idx)
        begin
          state_next.rx_state = uart_pkg::LINE_IDLE;
          accept = i_rxd; // see R12
          if (state_reg.frame_reg[uart_pkg::FF_MCE]
              && !state_reg.frame_reg[uart_pkg::FF_PE]) // see R13
          begin
            accept = i_rxd && state_reg.frame_reg[uart_pkg::FF_XBE]
                     && xbit; // see R12
          end
        end
      end
    end

    // Store an accepted byte; the set wins over a clear.
    if (accept)
    begin
      state_next.rx_ready = 1'b1; // see R4, R5
      state_next.rx_extra = has_x & xbit;
      if (state_reg.frame_reg[uart_pkg::FF_PE]
          && (xbit != parity_of(rx_data, nbits,
                                state_reg.frame_reg[uart_pkg::FF_PKIND_HI:
                                                    uart_pkg::FF_PKIND_LO])))
      begin
        state_next.par_err = 1'b1; // see R15
      end
      cnt = state_next.fifo_cnt;
      if (cnt == uart_pkg::FIFO_DEPTH)
      begin
        state_next.overrun = 1'b1; // see R1
      end
      else
      begin
        state_next.fifo[cnt] = rx_data; // see R1
        state_next.fifo_cnt = cnt + 2'h1;
      end
    end

    // Registered outputs.
    if (state_next.tx_state == uart_pkg::LINE_BUSY)
    begin
      state_next.txd = state_next.tx_frame[state_next.tx_hcnt[4:1]]; // see R17
    end
    else
    begin
      state_next.txd = 1'b1; // see R17
    end
    state_next.irq = state_next.rx_ready | state_next.tx_done; // see R4
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= '0;
      state_reg.frame_reg <= uart_pkg::FRAME_FORMAT_RST;
      state_reg.reload_lo_reg <= uart_pkg::RELOAD_RST;
      state_reg.reload_hi_reg <= uart_pkg::RELOAD_RST;
      state_reg.rx_prev <= 1'b1;
      state_reg.txd <= 1'b1;
    end
    else if (i_clk_en)
    begin
      state_reg <= state_next;
    end
  end

  assign o_sfr_rdata = state_reg.rdata;
  assign o_txd = state_reg.txd;
  assign o_irq_req = state_reg.irq;

endmodule : uart_with_baud_generator

// [common/uart_pkg.sv]
// Constants and types shared by the serial port design.
package uart_pkg;

  // --------------------------------------------------------------------
  // Register addresses on the special function register port
  // --------------------------------------------------------------------
  localparam logic [7:0] ADDR_FRAME_FORMAT = 8'hE5;
  localparam logic [7:0] ADDR_CONTROL = 8'hD2;
  localparam logic [7:0] ADDR_DATA = 8'hD3;
  localparam logic [7:0] ADDR_BAUD_CTL = 8'hAC;
  localparam logic [7:0] ADDR_RELOAD_LO = 8'hB4;
  localparam logic [7:0] ADDR_RELOAD_HI = 8'hB5;

  // --------------------------------------------------------------------
  // Values after reset
  // --------------------------------------------------------------------
  localparam logic [7:0] FRAME_FORMAT_RST = 8'h0C;
  localparam logic [7:0] RELOAD_RST = 8'h00;

  // --------------------------------------------------------------------
  // Field positions of the frame format register
  // --------------------------------------------------------------------
  localparam int FF_MCE = 7;
  localparam int FF_PKIND_HI = 6;
  localparam int FF_PKIND_LO = 5;
  localparam int FF_PE = 4;
  localparam int FF_DL_HI = 3;
  localparam int FF_DL_LO = 2;
  localparam int FF_XBE = 1;
  localparam int FF_SBL = 0;

  // --------------------------------------------------------------------
  // Field positions of the control and status register
  // --------------------------------------------------------------------
  localparam int CS_RX_READY = 0;
  localparam int CS_TX_DONE = 1;
  localparam int CS_RX_EXTRA = 2;
  localparam int CS_TX_EXTRA = 3;
  localparam int CS_RX_EN = 4;
  localparam int CS_PAR_ERR = 5;
  localparam int CS_OVERRUN = 6;
  localparam int CS_TX_BUSY = 7;

  // --------------------------------------------------------------------
  // Field positions of the baud generator control register
  // --------------------------------------------------------------------
  localparam int BC_ENABLE = 6;
  localparam int BC_PRESC_HI = 1;
  localparam int BC_PRESC_LO = 0;

  // --------------------------------------------------------------------
  // Prescaler terminal counts, ratio minus one
  // --------------------------------------------------------------------
  localparam logic [5:0] PRESC_END_1 = 6'h00;
  localparam logic [5:0] PRESC_END_4 = 6'h03;
  localparam logic [5:0] PRESC_END_12 = 6'h0B;
  localparam logic [5:0] PRESC_END_48 = 6'h2F;

  // --------------------------------------------------------------------
  // Counts and sizes
  // --------------------------------------------------------------------
  localparam logic [15:0] TIMER_TOP = 16'hFFFF;
  localparam logic [1:0] FIFO_DEPTH = 2'h3;
  localparam logic [3:0] DATA_BITS_MIN = 4'h5;
  localparam logic [4:0] STOP_HALF_SHORT = 5'h02;
  localparam logic [4:0] STOP_HALF_LONG = 5'h04;
  localparam logic [4:0] STOP_HALF_MID = 5'h03;

  // --------------------------------------------------------------------
  // Enumerations
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    PAR_ODD = 2'h0,
    PAR_EVEN = 2'h1,
    PAR_MARK = 2'h2,
    PAR_SPACE = 2'h3
  } parity_kind_t;

  typedef enum logic {
    LINE_IDLE = 1'h0,
    LINE_BUSY = 1'h1
  } line_state_t;

endpackage : uart_pkg

// [sim/uart_with_baud_generator_monitor.sv]
// Assertion checker for the serial port with baud generator.
`timescale 1ns/1ps

module uart_with_baud_generator_monitor (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  // Register port
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] o_sfr_rdata,
  // Serial lines and request
  input wire logic i_rxd,
  input wire logic o_txd,
  input wire logic o_irq_req
);
  // ----
  // Shadow registers
  // ----
  logic [7:0] ff_reg;
  logic [7:0] lo_reg;
  logic [7:0] hi_reg;
  logic [7:0] bc_reg;
  logic ctl_wr_reg;
  logic wr_ok;
  logic rd_ok;
  logic ctl_wr;
  logic mapped;
  int run_reg;
  int ratio;
  int bit_len;

  assign wr_ok = i_sfr_wr && i_clk_en;
  assign rd_ok = i_sfr_rd && i_clk_en && !i_sfr_wr;
  assign ctl_wr = wr_ok && i_sfr_addr == uart_pkg::ADDR_CONTROL;
  assign mapped = i_sfr_addr inside {uart_pkg::ADDR_FRAME_FORMAT,
    uart_pkg::ADDR_CONTROL, uart_pkg::ADDR_DATA, uart_pkg::ADDR_BAUD_CTL,
    uart_pkg::ADDR_RELOAD_LO, uart_pkg::ADDR_RELOAD_HI};
  assign bit_len = 2 * (32'h0001_0000 - int'({hi_reg, lo_reg})) * ratio;

  always_comb
  begin
    case (bc_reg[1:0])
      2'h0: ratio = 1;
      2'h1: ratio = 4;
      2'h2: ratio = 12;
      default: ratio = 48;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ff_reg <= 8'h0C;
      lo_reg <= 8'h00;
      hi_reg <= 8'h00;
      bc_reg <= 8'h00;
      ctl_wr_reg <= 1'b0;
      run_reg <= 0;
    end
    else
    begin
      ctl_wr_reg <= ctl_wr;
      if (i_clk_en)
        run_reg <= o_txd ? 0 : run_reg + 1;
      if (wr_ok && i_sfr_addr == uart_pkg::ADDR_FRAME_FORMAT)
        ff_reg <= i_sfr_wdata;
      if (wr_ok && i_sfr_addr == uart_pkg::ADDR_RELOAD_LO)
        lo_reg <= i_sfr_wdata;
      if (wr_ok && i_sfr_addr == uart_pkg::ADDR_RELOAD_HI)
        hi_reg <= i_sfr_wdata;
      if (wr_ok && i_sfr_addr == uart_pkg::ADDR_BAUD_CTL)
        bc_reg <= i_sfr_wdata;
    end
  end

  // ----
  // Assertions
  // ----
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_resetn);

  a_rdata_holds: assert property (
    !$past(i_sfr_rd) |-> $stable(o_sfr_rdata))
    else $error("Read data changed without a read.");
  a_frame_readback: assert property (
    rd_ok && i_sfr_addr == uart_pkg::ADDR_FRAME_FORMAT
    |=> o_sfr_rdata == ff_reg)
    else $error("Frame format read back wrong.");
  a_reload_readback: assert property (
    rd_ok && i_sfr_addr == uart_pkg::ADDR_RELOAD_LO
    |=> o_sfr_rdata == lo_reg)
    else $error("Reload read back wrong.");
  a_unmapped_zero: assert property (
    rd_ok && !mapped |=> o_sfr_rdata == 8'h00)
    else $error("Unmapped read not zero.");
  a_txd_idle_off: assert property (
    (!bc_reg[6]) [*3] |-> o_txd)
    else $error("Line active with baud disabled.");
  a_flags_idle_off: assert property (
    (!bc_reg[6]) [*3] ##0 !o_irq_req |=> !o_irq_req)
    else $error("Flag set with baud disabled.");
  a_irq_sticky: assert property (
    o_irq_req && !ctl_wr && !ctl_wr_reg |=> o_irq_req)
    else $error("Request dropped without a clear.");
  a_low_run_bound: assert property (
    bc_reg[6] |-> run_reg <= 10 * bit_len)
    else $error("Line low longer than a frame.");

endmodule : uart_with_baud_generator_monitor

bind uart_with_baud_generator uart_with_baud_generator_monitor
  uart_with_baud_generator_monitor_inst (.i_sys_clk, .i_resetn, .i_clk_en,
  .i_sfr_addr, .i_sfr_wdata, .i_sfr_wr, .i_sfr_rd, .o_sfr_rdata, .i_rxd,
  .o_txd, .o_irq_req);

// [sim/uart_remote_model.sv]
// Remote serial device on the far side of the serial lines.
`timescale 1ns/1ps

module uart_remote_model (
  // Clock
  input wire logic i_sys_clk,
  // Serial lines
  input wire logic i_txd,
  output logic o_rxd
);
  int bit_cyc = 16;
  int nbits = 8;
  logic xtra = 1'b0;
  logic [7:0] got = 8'h00;
  logic got_x = 1'b0;
  logic got_stop = 1'b0;
  int n_got = 0;

  initial o_rxd = 1'b1;

  task automatic put(input logic b);
    o_rxd = b;
    repeat (bit_cyc) @(posedge i_sys_clk);
    #1;
  endtask : put

  // Sends one frame; the line idles high afterwards.
  task automatic send(input logic [7:0] d, input logic x, input logic s);
    put(1'b0);
    for (int i = 0; i < nbits; i++)
      put(d[i]);
    if (xtra)
      put(x);
    put(s);
    put(1'b1);
    put(1'b1);
  endtask : send

  // Decodes frames sent by the port, sampling in mid bit.
  always
  begin
    @(negedge i_txd);
    got = 8'h00;
    repeat (bit_cyc / 2) @(posedge i_sys_clk);
    for (int i = 0; i < nbits; i++)
    begin
      repeat (bit_cyc) @(posedge i_sys_clk);
      got[i] = i_txd;
    end
    if (xtra)
    begin
      repeat (bit_cyc) @(posedge i_sys_clk);
      got_x = i_txd;
    end
    repeat (bit_cyc) @(posedge i_sys_clk);
    got_stop = i_txd;
    n_got++;
  end

endmodule : uart_remote_model

// [sim/uart_with_baud_generator_tb.sv]
// Self-checking testbench for the serial port with baud generator.
`timescale 1ns/1ps

module uart_with_baud_generator_tb;
  logic i_sys_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_clk_en = 1'b1;
  logic [7:0] i_sfr_addr = 8'h00;
  logic [7:0] i_sfr_wdata = 8'h00;
  logic i_sfr_wr = 1'b0;
  logic i_sfr_rd = 1'b0;
  logic [7:0] o_sfr_rdata;
  logic i_rxd;
  logic o_txd;
  logic o_irq_req;
  logic [7:0] v;
  int n;
  int n_mismatch = 0;
  int samples_checked = 0;
  int ratio [4] = '{1, 4, 12, 48};
  logic [7:0] mff [4] = '{8'h8E, 8'h8E, 8'h9E, 8'h0C};
  logic [3:0] par = 4'h6;
  logic [3:0] mx = 4'hA;
  logic [3:0] ms = 4'h7;

  always #50 i_sys_clk = ~i_sys_clk;

  uart_with_baud_generator uart_with_baud_generator_inst (.i_sys_clk,
    .i_resetn, .i_clk_en, .i_sfr_addr, .i_sfr_wdata, .i_sfr_wr,
    .i_sfr_rd, .o_sfr_rdata, .i_rxd, .o_txd, .o_irq_req);
  uart_remote_model uart_remote_model_inst (.i_sys_clk, .i_txd(o_txd),
    .o_rxd(i_rxd));

  // ----
  // Access and check tasks
  // ----
  task automatic chk(input string what, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, d);
    i_sfr_addr = a;
    i_sfr_wdata = d;
    i_sfr_wr = 1'b1;
    @(posedge i_sys_clk);
    #1 i_sfr_wr = 1'b0;
    @(posedge i_sys_clk);
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    i_sfr_addr = a;
    i_sfr_rd = 1'b1;
    @(posedge i_sys_clk);
    #1 i_sfr_rd = 1'b0;
    q = o_sfr_rdata;
    @(posedge i_sys_clk);
    #1;
  endtask : rd

  task automatic rdc(input string w, input logic [7:0] a, m, e);
    rd(a, v);
    chk(w, v & m, e);
  endtask : rdc

  task automatic guard(input int c);
    if (c > 20000)
    begin
      n_mismatch++;
      final_report();
    end
  endtask : guard

  task automatic wtx(input logic lvl, output int c);
    c = 0;
    while (o_txd !== lvl && c <= 20000)
    begin
      @(posedge i_sys_clk);
      #1 c = c + 1;
    end
    guard(c);
  endtask : wtx

  task automatic wrx(input int k, input int tail);
    n = 0;
    while (uart_remote_model_inst.n_got < k && n <= 20000)
    begin
      @(posedge i_sys_clk);
      #1 n = n + 1;
    end
    guard(n);
    repeat (tail) @(posedge i_sys_clk);
    #1;
  endtask : wrx

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  // ----
  // Test sequence
  // ----
  initial
  begin
    repeat (12) @(posedge i_sys_clk);
    #1 i_resetn = 1'b1;
    repeat (3) @(posedge i_sys_clk);
    #1;
    rdc("format", uart_pkg::ADDR_FRAME_FORMAT, 8'hFF, 8'h0C);
    rdc("control", uart_pkg::ADDR_CONTROL, 8'hFF, 8'h00);
    rdc("unmapped", 8'h99, 8'hFF, 8'h00);
    wr(uart_pkg::ADDR_FRAME_FORMAT, 8'h5A);
    rdc("format", uart_pkg::ADDR_FRAME_FORMAT, 8'hFF, 8'h5A);
    wr(uart_pkg::ADDR_FRAME_FORMAT, 8'h0C);
    i_clk_en = 1'b0;
    wr(uart_pkg::ADDR_FRAME_FORMAT, 8'h5A);
    i_clk_en = 1'b1;
    rdc("frozen", uart_pkg::ADDR_FRAME_FORMAT, 8'hFF, 8'h0C);
    $display("Test registers done");
    wr(uart_pkg::ADDR_CONTROL, 8'h10);
    wr(uart_pkg::ADDR_RELOAD_LO, 8'hF8);
    wr(uart_pkg::ADDR_RELOAD_HI, 8'hFF);
    rdc("reload", uart_pkg::ADDR_RELOAD_LO, 8'hFF, 8'hF8);
    uart_remote_model_inst.send(8'h55, 1'b0, 1'b1);
    rdc("off ready", uart_pkg::ADDR_CONTROL, 8'h01, 8'h00);
    chk("off line", o_txd, 1'b1);
    $display("Test disabled generator done");
    for (int p = 0; p < 4; p++)
    begin
      wr(uart_pkg::ADDR_BAUD_CTL, 8'h40 | 8'(p));
      uart_remote_model_inst.bit_cyc = 16 * ratio[p];
      wr(uart_pkg::ADDR_DATA, 8'h0F);
      wtx(1'b0, n);
      wtx(1'b1, n);
      wtx(1'b0, n);
      chk("bit time", 16'(n), 16'(64 * ratio[p]));
      wrx(p + 1, 16 * ratio[p]);
      chk("tx byte", uart_remote_model_inst.got, 8'h0F);
      rdc("tx done", uart_pkg::ADDR_CONTROL, 8'h02, 8'h02);
      chk("irq", o_irq_req, 1'b1);
      wr(uart_pkg::ADDR_CONTROL, 8'h10);
      chk("irq clear", o_irq_req, 1'b0);
    end
    wr(uart_pkg::ADDR_BAUD_CTL, 8'h40);
    uart_remote_model_inst.bit_cyc = 16;
    $display("Test baud rates done");
    uart_remote_model_inst.xtra = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      wr(uart_pkg::ADDR_FRAME_FORMAT, 8'h1C | 8'(k << 5));
      wr(uart_pkg::ADDR_DATA, 8'h07);
      wrx(5 + k, 16);
      chk("parity", uart_remote_model_inst.got_x, par[k]);
      chk("stop", uart_remote_model_inst.got_stop, 1'b1);
      wr(uart_pkg::ADDR_CONTROL, 8'h10);
    end
    wr(uart_pkg::ADDR_FRAME_FORMAT, 8'h0E);
    wr(uart_pkg::ADDR_CONTROL, 8'h18);
    wr(uart_pkg::ADDR_DATA, 8'h07);
    wrx(9, 16);
    chk("extra", uart_remote_model_inst.got_x, 1'b1);
    wr(uart_pkg::ADDR_CONTROL, 8'h10);
    $display("Test parity done");
    wr(uart_pkg::ADDR_FRAME_FORMAT, 8'h0C);
    uart_remote_model_inst.xtra = 1'b0;
    for (int i = 0; i < 4; i++)
      uart_remote_model_inst.send(8'hA1 + 8'(i), 1'b0, 1'b1);
    rdc("full", uart_pkg::ADDR_CONTROL, 8'h41, 8'h41);
    rdc("data", uart_pkg::ADDR_DATA, 8'hFF, 8'hA1);
    wr(uart_pkg::ADDR_CONTROL, 8'h10);
    rdc("kept ready", uart_pkg::ADDR_CONTROL, 8'h01, 8'h01);
    rdc("data", uart_pkg::ADDR_DATA, 8'hFF, 8'hA2);
    rdc("data", uart_pkg::ADDR_DATA, 8'hFF, 8'hA3);
    wr(uart_pkg::ADDR_CONTROL, 8'h10);
    rdc("cleared", uart_pkg::ADDR_CONTROL, 8'h41, 8'h00);
    $display("Test receive queue done");
    for (int j = 0; j < 4; j++)
    begin
      wr(uart_pkg::ADDR_FRAME_FORMAT, mff[j]);
      uart_remote_model_inst.xtra = mff[j][1];
      uart_remote_model_inst.send(8'h07, mx[j], ms[j]);
      rdc("accept", uart_pkg::ADDR_CONTROL, 8'h01, par[j]);
      rd(uart_pkg::ADDR_DATA, v);
      wr(uart_pkg::ADDR_CONTROL, 8'h10);
    end
    chk("irq idle", o_irq_req, 1'b0);
    $display("Test address check done");
    final_report();
  end

endmodule : uart_with_baud_generator_tb
